//--- logic/ocpk_pkg.sv
// Purpose: Shared constants and types for the overcurrent pick-up stage
// Assumes: 50 MHz clock, magnitudes and threshold in 0.01 x nominal units
// Notes: Status codes are the values seen by the display and event logic
package ocpk_pkg;
   // ****************************************
   // Widths and timing
   // ****************************************
   localparam int MAG_W = 16;
   localparam int CLK_MHZ = 50;
   localparam int PROG_CYCLE_US = 5000;
   localparam int PROG_CYCLE_CLKS = PROG_CYCLE_US * CLK_MHZ;
   localparam int STAMP_US = 1000;
   localparam int STAMP_CLKS = STAMP_US * CLK_MHZ;
   localparam logic [4:0] DIV_STEPS = 5'h18;
   // ****************************************
   // Settings after reset
   // ****************************************
   localparam logic [15:0] THRESH_RESET = 16'h0078;
   localparam logic [15:0] HARM_LIMIT_RESET = 16'h0001;
   localparam logic INRUSH_EN_RESET = 1'b0;
   localparam logic [23:0] PCT_FULL = 24'h000064;
   localparam logic [23:0] PCT_RESET_RATIO = 24'h000061;
   // ****************************************
   // Status encodings
   // ****************************************
   localparam logic [1:0] COND_NORMAL = 2'h0;
   localparam logic [1:0] COND_START = 2'h1;
   localparam logic [1:0] COND_TRIP = 2'h2;
   localparam logic [1:0] COND_BLOCKED = 2'h3;
   localparam logic [3:0] PH_NORMAL = 4'h0;
   localparam logic [3:0] PH_START_A = 4'h1;
   localparam logic [3:0] PH_TRIP_A = 4'h4;
   localparam logic [3:0] PH_START_AB = 4'h7;
   localparam logic [3:0] PH_START_ABC = 4'hA;
   localparam logic [3:0] PH_TRIP_AB = 4'hB;
   localparam logic [3:0] PH_TRIP_ABC = 4'hE;
   localparam logic [2:0] LN_ON = 3'h1;
   localparam logic [2:0] LN_BLOCKED = 3'h2;
   localparam logic [2:0] LN_TEST_BLOCKED = 3'h4;
   localparam logic [2:0] LN_OFF = 3'h5;
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCK} ocpk_state_t;
endpackage

//--- logic/ocpk_div_if.sv
// Purpose: Carrier between the stage and its ratio divider
// Assumes: One request in flight at a time
// Notes: Quotient holds from the done pulse until the next accepted start
`timescale 1ns/100ps
interface ocpk_div_if;
   logic start;
   logic [23:0] num;
   logic [15:0] den;
   logic done;
   logic [15:0] quot;
   modport ctrl (output start, output num, output den, input done, input quot);
   modport unit (input start, input num, input den, output done, output quot);
endinterface

//--- logic/ocpk_phase_cmp.sv
// Purpose: One phase threshold comparator with fixed release hysteresis
// Assumes: eval_in pulses once per program cycle
// Notes: Picked state only moves on eval_in
`timescale 1ns/100ps
module ocpk_phase_cmp (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic eval_in,
   input wire logic [15:0] mag_in,
   input wire logic [15:0] thresh_in,
   output logic picked_out
);
   logic [23:0] mag_scaled;
   logic [23:0] rel_scaled;
   logic above;
   logic below_rel;

   // Scaling both sides avoids a divider for the release level
   assign mag_scaled = 24'({8'h00, mag_in} * ocpk_pkg::PCT_FULL);
   assign rel_scaled = 24'({8'h00, thresh_in} * ocpk_pkg::PCT_RESET_RATIO);
   assign above = mag_in > thresh_in;
   assign below_rel = mag_scaled < rel_scaled;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         picked_out <= 1'b0;
      end else if (eval_in) begin
         if (above) begin
            picked_out <= 1'b1; // R1
         end else if (below_rel) begin
            picked_out <= 1'b0; // R2
         end
      end
   end

   chk_pick_on_above: assert property (@(posedge clock_in) disable iff (rst_in) // R1
      eval_in && above |=> picked_out)
      else $error("pick-up not taken above threshold");
   chk_hold_in_band: assert property (@(posedge clock_in) disable iff (rst_in) // R2
      eval_in && !above && !below_rel && picked_out |=> picked_out)
      else $error("pick-up released inside hysteresis band");
endmodule

//--- logic/ocpk_ratio_div.sv
// Purpose: Serial restoring divider for the current to threshold ratio
// Assumes: start is a one-cycle pulse, not repeated while busy
// Notes: Quotient saturates at all ones, also for a zero divisor
`timescale 1ns/100ps
module ocpk_ratio_div (
   input wire logic clock_in,
   input wire logic rst_in,
   ocpk_div_if.unit div
);
   logic [24:0] rem_q;
   logic [24:0] trial;
   logic [23:0] num_q;
   logic [23:0] quo_q;
   logic [4:0] cnt_q;
   logic busy_q;
   logic fin_q;

   // Trades 24 cycles of latency for no wide combinational divider
   assign trial = {rem_q[23:0], num_q[23]};
   assign div.done = fin_q;
   assign div.quot = (|quo_q[23:16]) ? 16'hFFFF : quo_q[15:0];

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rem_q <= 25'h0000000;
         num_q <= 24'h000000;
         quo_q <= 24'h000000;
         cnt_q <= 5'h00;
         busy_q <= 1'b0;
         fin_q <= 1'b0;
      end else begin
         fin_q <= busy_q && cnt_q == 5'h01;
         if (div.start && !busy_q) begin
            rem_q <= 25'h0000000;
            num_q <= div.num;
            quo_q <= 24'h000000;
            cnt_q <= ocpk_pkg::DIV_STEPS;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (trial >= {9'h000, div.den}) begin
               rem_q <= trial - {9'h000, div.den};
               quo_q <= {quo_q[22:0], 1'b1};
            end else begin
               rem_q <= trial;
               quo_q <= {quo_q[22:0], 1'b0};
            end
            num_q <= {num_q[22:0], 1'b0};
            cnt_q <= cnt_q - 5'h01;
            busy_q <= cnt_q != 5'h01;
         end
      end
   end

   chk_div_finishes: assert property (@(posedge clock_in) disable iff (rst_in) // R17
      div.start && !busy_q |-> ##25 fin_q)
      else $error("ratio divider did not finish in 25 cycles");
endmodule

//--- logic/ocpk_stage.sv
// Purpose: Phase overcurrent stage: pick-up, blocking, start, trip and status
// Assumes: Magnitudes come from logic on this clock; block_in is a pin
// Notes: Decisions happen once per program cycle, one clock after sampling
// Behaviour
// R1: Any phase above the shared threshold picks up.
// R2: Release only below 97 percent of the threshold.
// R3: Threshold in 0.01 nominal steps, default 1.20 nominal.
// R4: Pick-up is not start; start only without blocking.
// R5: Blocking is sampled at the start of each program cycle.
// R6: Pick-up without blocking asserts start and begins operate timing.
// R7: Pick-up under blocking asserts blocked and stops further processing.
// R8: Blocking after start drops start as a dropped pick-up would.
// R9: Blocking issues a display event and a stamped event with currents and phases.
// R10: The blocking source asserts at least 5 ms before the delay expires.
// R11: Inrush harmonic blocking has an enable, off by default.
// R12: Harmonic blocking limit held in 0.01 percent steps of fundamental.
// R13: Stage condition coded 0 normal, 1 start, 2 trip, 3 blocked.
// R14: Per-phase codes for single, dual and three-phase start and trip.
// R15: Expected operating time reported in 5 ms steps.
// R16: Remaining time to trip counts down in 5 ms steps.
// R17: Ratio of highest phase current to threshold in 0.01 steps.
// R18: Logical node behaviour reported as 1 to 5.
// R19: Under stage forcing a software switch drives blocking.
// R20: Start, trip and blocked edges stamped with 1 ms resolution.
// R21: Instant mode emits start and trip in one record, one stamp.
// R22: Trip when timing expires with start held; clear with start.
`timescale 1ns/100ps
module ocpk_stage #(
   parameter int PROG_CYCLE_CLKS = ocpk_pkg::PROG_CYCLE_CLKS,
   parameter int STAMP_CLKS = ocpk_pkg::STAMP_CLKS
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [15:0] mag_a_in,
   input wire logic [15:0] mag_b_in,
   input wire logic [15:0] mag_c_in,
   input wire logic block_in,
   input wire logic settings_load_in,
   input wire logic [15:0] thresh_in,
   input wire logic inrush_enable_in,
   input wire logic [15:0] harm_limit_in,
   input wire logic [15:0] harm_fraction_in,
   input wire logic [15:0] op_delay_in,
   input wire logic [2:0] ln_mode_in,
   input wire logic forcing_enable_in,
   input wire logic forced_block_in,
   output logic start_out,
   output logic trip_out,
   output logic blocked_out,
   output logic [1:0] condition_out,
   output logic [3:0] phase_condition_out,
   output logic [15:0] expected_time_out,
   output logic [15:0] remaining_out,
   output logic [15:0] ratio_out,
   output logic [2:0] logical_node_behaviour_out,
   output logic display_event_out,
   output logic event_valid_out,
   output logic [5:0] event_flags_out,
   output logic [31:0] event_stamp_out,
   output logic [15:0] event_current_out,
   output logic [2:0] event_fault_out
);
   // ****************************************
   // Declarations
   // ****************************************
   ocpk_div_if div_bus ();
   ocpk_pkg::ocpk_state_t state_q, state_d;
   logic blk_meta_q, blk_sync_q, blk_sample_q, tick_q, decide_q, inrush_en_q;
   logic [31:0] cyc_cnt_q, ms_cnt_q, stamp_q;
   logic [15:0] thresh_q, harm_limit_q, remain_q, remain_d, mag_max;
   logic [2:0] picked;
   logic any_pick, block_src, ln_block, ln_off;
   logic start_prev_q, trip_prev_q, blk_prev_q;
   logic [5:0] edges;
   // ****************************************
   // Phase comparators
   // ****************************************
   for (genvar p = 0; p < 3; p++) begin : g_phase
      ocpk_phase_cmp u_cmp (
         .clock_in(clock_in),
         .rst_in(rst_in),
         .eval_in(tick_q),
         .mag_in(p == 0 ? mag_a_in : (p == 1 ? mag_b_in : mag_c_in)),
         .thresh_in(thresh_q),
         .picked_out(picked[p])
      );
   end
   assign any_pick = |picked; // R1
   assign mag_max = (mag_a_in >= mag_b_in && mag_a_in >= mag_c_in) ? mag_a_in :
                    (mag_b_in >= mag_c_in) ? mag_b_in : mag_c_in;
   // ****************************************
   // Settings and program cycle pacing
   // ****************************************
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         thresh_q <= ocpk_pkg::THRESH_RESET; // R3
         harm_limit_q <= ocpk_pkg::HARM_LIMIT_RESET; // R12
         inrush_en_q <= ocpk_pkg::INRUSH_EN_RESET; // R11
      end else if (settings_load_in) begin
         thresh_q <= thresh_in; // R3
         harm_limit_q <= harm_limit_in; // R12
         inrush_en_q <= inrush_enable_in; // R11
      end
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cyc_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
         decide_q <= 1'b0;
      end else begin
         tick_q <= cyc_cnt_q == 32'(PROG_CYCLE_CLKS - 1);
         cyc_cnt_q <= (cyc_cnt_q == 32'(PROG_CYCLE_CLKS - 1)) ? 32'h00000000 :
                      cyc_cnt_q + 32'h00000001;
         decide_q <= tick_q;
      end
   end
   // ****************************************
   // Blocking sources
   // ****************************************
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         blk_meta_q <= 1'b0;
         blk_sync_q <= 1'b0;
      end else begin
         blk_meta_q <= block_in;
         blk_sync_q <= blk_meta_q;
      end
   end
   assign ln_block = ln_mode_in == ocpk_pkg::LN_BLOCKED ||
                     ln_mode_in == ocpk_pkg::LN_TEST_BLOCKED;
   assign ln_off = ln_mode_in == ocpk_pkg::LN_OFF;
   // Forcing replaces the matrix input so commissioning needs no wiring
   assign block_src = (forcing_enable_in ? forced_block_in : blk_sync_q) || // R19
                      (inrush_en_q && harm_fraction_in >= harm_limit_q) || // R11 R12
                      ln_block;
   // Sampled on the same tick that evaluates the comparators
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         blk_sample_q <= 1'b0;
      end else if (tick_q) begin
         blk_sample_q <= block_src; // R5
      end
   end
   // ****************************************
   // Stage state machine
   // ****************************************
   always_comb begin
      state_d = state_q;
      remain_d = remain_q;
      if (decide_q) begin
         case (state_q)
            ocpk_pkg::ST_IDLE: begin
               if (any_pick && blk_sample_q) begin
                  state_d = ocpk_pkg::ST_BLOCK; // R7
               end else if (any_pick && op_delay_in == 16'h0000) begin
                  state_d = ocpk_pkg::ST_TRIP; // R21
               end else if (any_pick) begin
                  state_d = ocpk_pkg::ST_START; // R4 R6
                  remain_d = op_delay_in; // R16
               end
            end
            ocpk_pkg::ST_START: begin
               if (!any_pick) begin
                  state_d = ocpk_pkg::ST_IDLE;
               end else if (blk_sample_q) begin
                  state_d = ocpk_pkg::ST_BLOCK; // R8
               end else if (remain_q <= 16'h0001) begin
                  state_d = ocpk_pkg::ST_TRIP; // R22
               end else begin
                  remain_d = remain_q - 16'h0001; // R16
               end
            end
            ocpk_pkg::ST_TRIP: begin
               if (!any_pick) begin
                  state_d = ocpk_pkg::ST_IDLE; // R22
               end else if (blk_sample_q) begin
                  state_d = ocpk_pkg::ST_BLOCK;
               end
            end
            ocpk_pkg::ST_BLOCK: begin
               if (!any_pick || !blk_sample_q) begin
                  state_d = ocpk_pkg::ST_IDLE;
               end
            end
            default: state_d = ocpk_pkg::ST_IDLE;
         endcase
         if (ln_off) begin
            state_d = ocpk_pkg::ST_IDLE;
         end
      end
      if (state_d != ocpk_pkg::ST_START) begin
         remain_d = 16'h0000;
      end
   end
   function automatic logic [3:0] phase_code(input logic [2:0] m, input logic trip);
      case (m)
         3'b001: return trip ? ocpk_pkg::PH_TRIP_A : ocpk_pkg::PH_START_A;
         3'b010: return (trip ? ocpk_pkg::PH_TRIP_A : ocpk_pkg::PH_START_A) + 4'h1;
         3'b100: return (trip ? ocpk_pkg::PH_TRIP_A : ocpk_pkg::PH_START_A) + 4'h2;
         3'b011: return trip ? ocpk_pkg::PH_TRIP_AB : ocpk_pkg::PH_START_AB;
         3'b110: return (trip ? ocpk_pkg::PH_TRIP_AB : ocpk_pkg::PH_START_AB) + 4'h1;
         3'b101: return (trip ? ocpk_pkg::PH_TRIP_AB : ocpk_pkg::PH_START_AB) + 4'h2;
         3'b111: return trip ? ocpk_pkg::PH_TRIP_ABC : ocpk_pkg::PH_START_ABC;
         default: return ocpk_pkg::PH_NORMAL;
      endcase
   endfunction
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_q <= ocpk_pkg::ST_IDLE;
         remain_q <= 16'h0000;
         start_out <= 1'b0;
         trip_out <= 1'b0;
         blocked_out <= 1'b0;
         condition_out <= ocpk_pkg::COND_NORMAL;
         phase_condition_out <= ocpk_pkg::PH_NORMAL;
      end else begin
         state_q <= state_d;
         remain_q <= remain_d;
         start_out <= state_d == ocpk_pkg::ST_START || state_d == ocpk_pkg::ST_TRIP; // R4
         trip_out <= state_d == ocpk_pkg::ST_TRIP; // R22
         blocked_out <= state_d == ocpk_pkg::ST_BLOCK; // R7
         case (state_d)
            ocpk_pkg::ST_START: condition_out <= ocpk_pkg::COND_START; // R13
            ocpk_pkg::ST_TRIP: condition_out <= ocpk_pkg::COND_TRIP;
            ocpk_pkg::ST_BLOCK: condition_out <= ocpk_pkg::COND_BLOCKED;
            default: condition_out <= ocpk_pkg::COND_NORMAL;
         endcase
         phase_condition_out <= (state_d == ocpk_pkg::ST_START || state_d == ocpk_pkg::ST_TRIP) ?
                                phase_code(picked, state_d == ocpk_pkg::ST_TRIP) : // R14
                                ocpk_pkg::PH_NORMAL;
      end
   end
   // ****************************************
   // Info values
   // ****************************************
   // Only definite delay is timed here; curve evaluation lives upstream
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         expected_time_out <= 16'h0000;
         remaining_out <= 16'h0000;
         ratio_out <= 16'h0000;
         logical_node_behaviour_out <= ocpk_pkg::LN_ON;
      end else begin
         expected_time_out <= op_delay_in; // R15
         remaining_out <= remain_d; // R16
         if (div_bus.done) begin
            ratio_out <= div_bus.quot; // R17
         end
         logical_node_behaviour_out <= (ln_mode_in >= ocpk_pkg::LN_ON && ln_mode_in <= ocpk_pkg::LN_OFF) ?
                             ln_mode_in : ocpk_pkg::LN_ON; // R18
      end
   end
   assign div_bus.start = decide_q;
   assign div_bus.num = 24'({8'h00, mag_max} * ocpk_pkg::PCT_FULL); // R17
   assign div_bus.den = thresh_q;
   ocpk_ratio_div u_div (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .div(div_bus.unit)
   );
   // ****************************************
   // Events and time stamps
   // ****************************************
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ms_cnt_q <= 32'h00000000;
         stamp_q <= 32'h00000000;
      end else if (ms_cnt_q == 32'(STAMP_CLKS - 1)) begin
         ms_cnt_q <= 32'h00000000;
         stamp_q <= stamp_q + 32'h00000001; // R20
      end else begin
         ms_cnt_q <= ms_cnt_q + 32'h00000001;
      end
   end
   assign edges = {start_out & ~start_prev_q, ~start_out & start_prev_q,
                   trip_out & ~trip_prev_q, ~trip_out & trip_prev_q,
                   blocked_out & ~blk_prev_q, ~blocked_out & blk_prev_q};
   // One record carries all edges of a decision, so instant start and trip share a stamp
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         start_prev_q <= 1'b0;
         trip_prev_q <= 1'b0;
         blk_prev_q <= 1'b0;
         event_valid_out <= 1'b0;
         event_flags_out <= 6'h00;
         event_stamp_out <= 32'h00000000;
         event_current_out <= 16'h0000;
         event_fault_out <= 3'h0;
         display_event_out <= 1'b0;
      end else begin
         start_prev_q <= start_out;
         trip_prev_q <= trip_out;
         blk_prev_q <= blocked_out;
         event_valid_out <= |edges; // R20 R21
         display_event_out <= edges[1]; // R9
         if (|edges) begin
            event_flags_out <= edges;
            event_stamp_out <= stamp_q; // R20
            event_current_out <= mag_max; // R9
            event_fault_out <= picked; // R9
         end
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   chk_block_at_pick: assert property (@(posedge clock_in) disable iff (rst_in) // R7
      decide_q && state_q == ocpk_pkg::ST_IDLE && any_pick && blk_sample_q && !ln_off
      |=> blocked_out && !start_out)
      else $error("blocked pick-up did not give blocked");
   chk_start_when_free: assert property (@(posedge clock_in) disable iff (rst_in) // R6
      decide_q && state_q == ocpk_pkg::ST_IDLE && any_pick && !blk_sample_q && !ln_off
      && op_delay_in != 16'h0000 |=> start_out && !trip_out && !blocked_out)
      else $error("free pick-up did not give start");
   chk_block_drops_start: assert property (@(posedge clock_in) disable iff (rst_in) // R8
      decide_q && state_q == ocpk_pkg::ST_START && any_pick && blk_sample_q && !ln_off
      |=> !start_out ##1 display_event_out)
      else $error("late blocking did not drop start");
   chk_instant_record: assert property (@(posedge clock_in) disable iff (rst_in) // R21
      decide_q && state_q == ocpk_pkg::ST_IDLE && any_pick && !blk_sample_q && !ln_off
      && op_delay_in == 16'h0000 |=> ##1 event_valid_out && event_flags_out[5]
      && event_flags_out[3])
      else $error("instant start and trip not in one record");
   chk_trip_clears: assert property (@(posedge clock_in) disable iff (rst_in) // R22
      trip_out && decide_q && !any_pick |=> !trip_out && !start_out)
      else $error("trip held after pick-up release");
   chk_cond_code: assert property (@(posedge clock_in) disable iff (rst_in) // R13
      (condition_out == ocpk_pkg::COND_BLOCKED) == blocked_out
      && (condition_out == ocpk_pkg::COND_TRIP) == trip_out)
      else $error("condition code disagrees with outputs");
   chk_sample_first: assert property (@(posedge clock_in) disable iff (rst_in) // R5
      tick_q |=> decide_q && blk_sample_q == $past(block_src))
      else $error("blocking not sampled before decision");
   chk_countdown: assert property (@(posedge clock_in) disable iff (rst_in) // R16
      decide_q && state_q == ocpk_pkg::ST_START && any_pick && !blk_sample_q && !ln_off
      && remain_q > 16'h0001 |=> remaining_out == $past(remain_q) - 16'h0001)
      else $error("remaining time did not count down");
endmodule

//--- verif/ocpk_front_model.sv
// Purpose: Front end and blocking matrix model facing the stage
// Assumes: Requests change one small delay after a clock edge
// Notes: Pins follow the request one edge later, never mid-cycle
`timescale 1ns/100ps
module ocpk_front_model (
   input wire logic clock_in,
   input wire logic [47:0] mag_req_in,
   input wire logic block_req_in,
   output logic [15:0] mag_a_out,
   output logic [15:0] mag_b_out,
   output logic [15:0] mag_c_out,
   output logic block_out
);
   // ****************************************
   // Pin drive
   // ****************************************
   logic [47:0] mag_hold;
   logic block_hold;
   initial begin
      {mag_a_out, mag_b_out, mag_c_out, block_out} = '0;
   end
   // Taken at the edge, so a request set just after the last edge is read settled
   always @(posedge clock_in) begin
      mag_hold = mag_req_in;
      block_hold = block_req_in;
      #1;
      {mag_a_out, mag_b_out, mag_c_out} = mag_hold;
      block_out = block_hold;
   end
endmodule

//--- verif/ocpk_stage_bench.sv
// Purpose: Self-checking bench for the overcurrent stage
// Assumes: Short program cycle of 20 clocks
// Notes: Each step waits whole program cycles, then compares
`timescale 1ns/100ps
module ocpk_stage_bench;
   localparam int PC = 20;
   logic clock_in, rst_in, blk, bk_pin, load, inr, fen, fblk, st, tr, bl, dsp, ev;
   logic [47:0] mreq;
   logic [15:0] ma, mb, mc, thr, hlim, hfr, opd, et, rem, rat, evc;
   logic [2:0] lnm, lno, evp;
   logic [1:0] cnd;
   logic [3:0] ph;
   logic [5:0] evf;
   logic [31:0] evs;
   int err_total, checked, dsp_n, ev_n;
   ocpk_front_model i_front (.clock_in(clock_in), .mag_req_in(mreq), .block_req_in(blk),
      .mag_a_out(ma), .mag_b_out(mb), .mag_c_out(mc), .block_out(bk_pin));
   ocpk_stage #(.PROG_CYCLE_CLKS(PC), .STAMP_CLKS(8)) i_dut (.clock_in(clock_in),
      .rst_in(rst_in), .mag_a_in(ma), .mag_b_in(mb), .mag_c_in(mc), .block_in(bk_pin),
      .settings_load_in(load), .thresh_in(thr), .inrush_enable_in(inr),
      .harm_limit_in(hlim), .harm_fraction_in(hfr), .op_delay_in(opd), .ln_mode_in(lnm),
      .forcing_enable_in(fen), .forced_block_in(fblk), .start_out(st), .trip_out(tr),
      .blocked_out(bl), .condition_out(cnd), .phase_condition_out(ph),
      .expected_time_out(et), .remaining_out(rem), .ratio_out(rat),
      .logical_node_behaviour_out(lno), .display_event_out(dsp), .event_valid_out(ev),
      .event_flags_out(evf), .event_stamp_out(evs), .event_current_out(evc),
      .event_fault_out(evp));
   // ****************************************
   // Clock, pulse count and tasks
   // ****************************************
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   // Pulses are counted mid-cycle, where they have settled
   always @(negedge clock_in) begin
      if (dsp === 1'b1) dsp_n++;
      if (ev === 1'b1) ev_n++;
   end
   task chk(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // Holds magnitudes and blocking for n program cycles
   task go(input logic [15:0] a, b, c, input logic k, input int n);
      mreq = {a, b, c};
      blk = k;
      repeat (n * PC) @(posedge clock_in);
      #1;
   endtask
   task tally_and_finish;
      if (err_total == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #300000;
      err_total++;
      tally_and_finish;
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin : tests
      logic [47:0] tb [7];
      logic [3:0] tc [7];
      tb = '{{16'h00F0, 16'h0, 16'h0}, {16'h0, 16'h00F0, 16'h0}, {16'h0, 16'h0, 16'h00F0},
         {16'h00F0, 16'h00F0, 16'h0}, {16'h0, 16'h00F0, 16'h00F0},
         {16'h00F0, 16'h0, 16'h00F0}, {16'h00F0, 16'h00F0, 16'h00F0}};
      tc = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA};
      {err_total, checked, dsp_n, ev_n} = '0;
      {blk, load, inr, fen, fblk, mreq} = '0;
      {thr, hlim, hfr} = {16'h0078, 16'h0001, 16'h0000};
      opd = 16'h0064;
      lnm = 3'h1;
      rst_in = 1'b1;
      repeat (4) @(posedge clock_in);
      #1 rst_in = 1'b0;
      chk(lno, 16'h1);
      chk(cnd, 16'h0);
      go(16'h0078, 16'h0, 16'h0, 1'b0, 2);
      chk(cnd, 16'h0);
      go(16'h0079, 16'h0, 16'h0, 1'b0, 2);
      chk(st, 16'h1);
      chk(cnd, 16'h1);
      chk(et, 16'h0064);
      chk(rem, 16'h0064);
      go(16'h0075, 16'h0, 16'h0, 1'b0, 2);
      chk(st, 16'h1);
      go(16'h0074, 16'h0, 16'h0, 1'b0, 2);
      chk(cnd, 16'h0);
      for (int i = 0; i < 7; i++) begin
         go(tb[i][47:32], tb[i][31:16], tb[i][15:0], 1'b0, 2);
         chk(ph, tc[i]);
      end
      chk(rat, 16'h00C8);
      go(16'h00F0, 16'h00F0, 16'h00F0, 1'b1, 2);
      chk({st, bl, cnd}, 16'h7);
      chk(dsp_n, 16'h1);
      // Leaving blocked goes through idle, so start comes one decision later
      go(16'h00F0, 16'h00F0, 16'h00F0, 1'b0, 3);
      chk(st, 16'h1);
      go(16'h0, 16'h0, 16'h0, 1'b1, 2);
      go(16'h00F0, 16'h0, 16'h0, 1'b1, 2);
      chk({st, bl}, 16'h1);
      opd = 16'h0002;
      go(16'h00F0, 16'h0, 16'h0, 1'b0, 5);
      chk({tr, cnd, ph}, 16'h64);
      go(16'h0, 16'h0, 16'h0, 1'b0, 2);
      chk(tr, 16'h0);
      opd = 16'h0000;
      go(16'h00F0, 16'h0, 16'h0, 1'b0, 2);
      chk(tr, 16'h1);
      chk({evf, evp}, 16'h0141);
      chk(evc, 16'h00F0);
      chk(evs[15:0], 16'h0061);
      chk(16'(ev_n), 16'h000D);
      go(16'h0, 16'h0, 16'h0, 1'b0, 2);
      {opd, inr, hlim, hfr, thr} = {16'h0064, 1'b1, 16'h0064, 16'h0064, 16'h00C8};
      load = 1'b1;
      @(posedge clock_in);
      #1 load = 1'b0;
      go(16'h00C9, 16'h0, 16'h0, 1'b0, 2);
      chk(bl, 16'h1);
      hfr = 16'h0063;
      go(16'h00C9, 16'h0, 16'h0, 1'b0, 3);
      chk({st, bl}, 16'h2);
      {fen, fblk} = 2'h3;
      go(16'h00C9, 16'h0, 16'h0, 1'b0, 2);
      chk(bl, 16'h1);
      {fen, fblk} = 2'h0;
      lnm = 3'h5;
      go(16'h00C9, 16'h0, 16'h0, 1'b0, 2);
      chk({lno, cnd}, 16'h14);
      lnm = 3'h2;
      go(16'h00C9, 16'h0, 16'h0, 1'b0, 2);
      chk(bl, 16'h1);
      tally_and_finish;
   end
endmodule
